// File: src/probe_capture_pkg.sv
// Operation
// - Capture position from either an external quadrature encoder, counted here, or a serial motor encoder.
// - Quadrature source: probe event copies the live count into the holding value at once.
// - Probe input passes a filter whose delay is selectable between 100 ns and 0.5 ms.
// - Motor encoder position is read over the serial link once every 125 us.
// - Motor source: probe moment is time-stamped relative to the latest sample.
// - Motor capture interpolates sampled position using velocity and the event timestamp.
// - Velocity is the first preceding sample minus the second, over the sampling period.
// - At constant velocity the interpolated capture lies within one count of the truth.
// - No acceleration term; only measured velocity times elapsed time is added.
package probe_capture_pkg;
   // ---------------------------------------------------------------
   // Timing, all counts derived from the 100 MHz clock
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int FILT_MIN_NS = 100;
   localparam int FILT_MAX_NS = 500000;
   localparam int SAMPLE_PERIOD_US = 125;
   // Least time rounds up, longest rounds down
   localparam int FILT_FAST_CYC = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_SLOW_CYC = FILT_MAX_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_CYC = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
   // ---------------------------------------------------------------
   // Widths and serial link shape
   // ---------------------------------------------------------------
   localparam int POS_W = 32;
   localparam int TS_W = 16;
   localparam int FILT_CNT_W = 16;
   localparam int SCLK_HALF_CYC = 5;
   localparam logic [1:0] QUAD_RESET = 2'h0;
endpackage : probe_capture_pkg

// File: src/probe_input_filter.sv
`timescale 1ns/1ns
module probe_input_filter #(
   parameter int CNT_W = probe_capture_pkg::FILT_CNT_W,
   parameter logic [CNT_W-1:0] FAST_CYC = CNT_W'(probe_capture_pkg::FILT_FAST_CYC),
   parameter logic [CNT_W-1:0] SLOW_CYC = CNT_W'(probe_capture_pkg::FILT_SLOW_CYC)
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic probe_sync,
   input wire logic filt_slow,
   output logic probe_evt
);
   logic level;
   logic next_level;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] limit;
   logic next_evt;

   // Level must stay changed for the full delay; glitches restart it
   always_comb begin
      limit = filt_slow ? SLOW_CYC : FAST_CYC;
      next_level = level;
      next_cnt = '0;
      next_evt = 1'b0;
      if (probe_sync != level) begin
         if (cnt >= limit - 1'b1) begin
            next_level = probe_sync;
            next_evt = probe_sync;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   // Filter registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         level <= 1'b0;
         cnt <= '0;
         probe_evt <= 1'b0;
      end else begin
         level <= next_level;
         cnt <= next_cnt;
         probe_evt <= next_evt;
      end
   end

   a_filter_delay: assert property (@(posedge mclk) disable iff (sys_rst)
      $changed(level) |-> $past(cnt) >= $past(limit) - 1'b1)
      else $error("filter output changed before its delay");
endmodule : probe_input_filter

// File: src/probe_position_capture.sv
`timescale 1ns/1ns
module probe_position_capture #(
   parameter int POS_W = probe_capture_pkg::POS_W,
   parameter int TS_W = probe_capture_pkg::TS_W,
   parameter int SAMPLE_CYC = probe_capture_pkg::SAMPLE_CYC,
   parameter int FILT_SLOW_CYC = probe_capture_pkg::FILT_SLOW_CYC,
   parameter int SCLK_HALF = probe_capture_pkg::SCLK_HALF_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic probe_in,
   input wire logic filt_slow,
   input wire logic src_motor,
   input wire logic quad_a,
   input wire logic quad_b,
   input wire logic enc_sdi,
   input wire logic cap_read,
   output logic enc_sclk,
   output logic enc_cs_n,
   output logic [POS_W-1:0] capture_pos,
   output logic capture_done
);
   localparam int PROD_W = POS_W + TS_W;
   localparam int BC_W = $clog2(POS_W + 1);
   localparam int DC_W = $clog2(PROD_W + 1);
   localparam int HD_W = $clog2(SCLK_HALF + 1);
   localparam logic [TS_W-1:0] N_CYC = TS_W'(SAMPLE_CYC);
   localparam logic [TS_W-1:0] LAST_TICK = TS_W'(SAMPLE_CYC - 1);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [3:0] sync1, sync2;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {probe_in, quad_a, quad_b, enc_sdi};
         sync2 <= sync1;
      end
   end

   logic probe_evt;
   probe_input_filter #(
      .CNT_W(probe_capture_pkg::FILT_CNT_W),
      .FAST_CYC(probe_capture_pkg::FILT_CNT_W'(probe_capture_pkg::FILT_FAST_CYC)),
      .SLOW_CYC(probe_capture_pkg::FILT_CNT_W'(FILT_SLOW_CYC))
   ) u_filter (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .probe_sync(sync2[3]),
      .filt_slow(filt_slow),
      .probe_evt(probe_evt)
   );

   // ---------------------------------------------------------------
   // Quadrature counter
   // ---------------------------------------------------------------
   logic [1:0] quad_prev;
   logic [POS_W-1:0] quad_count, next_quad_count;
   // x4 decode; illegal double steps are dropped rather than guessed
   always_comb begin
      case ({quad_prev, sync2[2:1]})
         4'h1, 4'h7, 4'he, 4'h8: next_quad_count = quad_count + 1'b1;
         4'h2, 4'hb, 4'hd, 4'h4: next_quad_count = quad_count - 1'b1;
         default: next_quad_count = quad_count;
      endcase
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         quad_prev <= probe_capture_pkg::QUAD_RESET;
         quad_count <= '0;
      end else begin
         quad_prev <= sync2[2:1];
         quad_count <= next_quad_count;
      end
   end

   // ---------------------------------------------------------------
   // Serial encoder sampling
   // ---------------------------------------------------------------
   typedef enum logic {ser_idle, ser_run} ser_type;
   ser_type ser_st, next_ser_st;
   logic [TS_W-1:0] period_cnt, next_period_cnt, elapsed, next_elapsed;
   logic [HD_W-1:0] hdiv, next_hdiv;
   logic [BC_W-1:0] bit_cnt, next_bit_cnt;
   logic [POS_W-1:0] shreg, next_shreg;
   logic [POS_W-1:0] v1, next_v1, v2, next_v2;
   logic have_one, next_have_one, next_sclk, next_cs_n, tick;
   // Sample instant is the tick; elapsed counts from it for the held sample
   always_comb begin
      tick = (period_cnt == LAST_TICK);
      next_period_cnt = tick ? '0 : period_cnt + 1'b1;
      next_elapsed = elapsed + 1'b1;
      next_ser_st = ser_st;
      next_hdiv = hdiv;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_v1 = v1;
      next_v2 = v2;
      next_have_one = have_one;
      next_sclk = enc_sclk;
      next_cs_n = enc_cs_n;
      case (ser_st)
         ser_idle: begin
            if (tick) begin
               next_ser_st = ser_run;
               next_cs_n = 1'b0;
               next_hdiv = '0;
               next_bit_cnt = '0;
            end
         end
         ser_run: begin
            next_hdiv = hdiv + 1'b1;
            if (hdiv == HD_W'(SCLK_HALF - 1)) begin
               next_hdiv = '0;
               if (!enc_sclk && bit_cnt != BC_W'(POS_W)) begin
                  next_sclk = 1'b1;
                  next_shreg = {shreg[POS_W-2:0], sync2[0]};
                  next_bit_cnt = bit_cnt + 1'b1;
               end else if (enc_sclk) begin
                  next_sclk = 1'b0;
               end else begin
                  // Word complete: shift the sample history
                  next_ser_st = ser_idle;
                  next_cs_n = 1'b1;
                  next_v1 = shreg;
                  next_v2 = have_one ? v1 : shreg;
                  next_have_one = 1'b1;
                  next_elapsed = period_cnt + 1'b1;
               end
            end
         end
         default: next_ser_st = ser_idle;
      endcase
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ser_st <= ser_idle;
         period_cnt <= '0;
         elapsed <= '0;
         hdiv <= '0;
         bit_cnt <= '0;
         shreg <= '0;
         v1 <= '0;
         v2 <= '0;
         have_one <= 1'b0;
         enc_sclk <= 1'b0;
         enc_cs_n <= 1'b1;
      end else begin
         ser_st <= next_ser_st;
         period_cnt <= next_period_cnt;
         elapsed <= next_elapsed;
         hdiv <= next_hdiv;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         v1 <= next_v1;
         v2 <= next_v2;
         have_one <= next_have_one;
         enc_sclk <= next_sclk;
         enc_cs_n <= next_cs_n;
      end
   end

   // ---------------------------------------------------------------
   // Capture and interpolation
   // ---------------------------------------------------------------
   typedef enum logic {cap_idle, cap_div} cap_type;
   cap_type cap_st, next_cap_st;
   logic [POS_W-1:0] v1s, next_v1s, v2s, next_v2s;
   logic [TS_W-1:0] stamp, next_stamp, rem, next_rem;
   logic [PROD_W-1:0] dvd, next_dvd, quo, next_quo, quo_step;
   logic [TS_W:0] rem_sh;
   logic [DC_W-1:0] div_cnt, next_div_cnt;
   logic neg, next_neg, next_capture_done, finish;
   logic [POS_W-1:0] diff, absdiff, step, next_capture_pos;
   // Divide by the period bit-serially; a cheap divider beats a wide one
   always_comb begin
      diff = v1 - v2;
      absdiff = diff[POS_W-1] ? -diff : diff;
      rem_sh = {rem, dvd[PROD_W-1]};
      quo_step = {quo[PROD_W-2:0], rem_sh >= {1'b0, N_CYC}};
      step = neg ? -quo_step[POS_W-1:0] : quo_step[POS_W-1:0];
      finish = (cap_st == cap_div) && (div_cnt == DC_W'(PROD_W - 1));
      next_cap_st = cap_st;
      next_v1s = v1s;
      next_v2s = v2s;
      next_stamp = stamp;
      next_dvd = dvd;
      next_quo = quo;
      next_rem = rem;
      next_div_cnt = div_cnt;
      next_neg = neg;
      next_capture_pos = capture_pos;
      next_capture_done = capture_done;
      if (cap_read) begin
         next_capture_done = 1'b0;
      end
      case (cap_st)
         cap_idle: ;
         cap_div: begin
            next_rem = rem_sh >= {1'b0, N_CYC} ? TS_W'(rem_sh - {1'b0, N_CYC}) : rem_sh[TS_W-1:0];
            next_quo = quo_step;
            next_dvd = {dvd[PROD_W-2:0], 1'b0};
            next_div_cnt = div_cnt + 1'b1;
            if (finish) begin
               next_cap_st = cap_idle;
               next_capture_pos = v1s + step;
               next_capture_done = 1'b1;
            end
         end
         default: next_cap_st = cap_idle;
      endcase
      // A new event always overwrites, including a division in flight
      if (probe_evt && !src_motor) begin
         next_cap_st = cap_idle;
         next_capture_pos = quad_count;
         next_capture_done = 1'b1;
      end else if (probe_evt) begin
         next_cap_st = cap_div;
         next_v1s = v1;
         next_v2s = v2;
         next_stamp = elapsed;
         next_neg = diff[POS_W-1];
         // Rounded quotient of velocity times elapsed time
         next_dvd = PROD_W'(absdiff * elapsed) + PROD_W'(N_CYC >> 1);
         next_quo = '0;
         next_rem = '0;
         next_div_cnt = '0;
      end
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cap_st <= cap_idle;
         v1s <= '0;
         v2s <= '0;
         stamp <= '0;
         dvd <= '0;
         quo <= '0;
         rem <= '0;
         div_cnt <= '0;
         neg <= 1'b0;
         capture_pos <= '0;
         capture_done <= 1'b0;
      end else begin
         cap_st <= next_cap_st;
         v1s <= next_v1s;
         v2s <= next_v2s;
         stamp <= next_stamp;
         dvd <= next_dvd;
         quo <= next_quo;
         rem <= next_rem;
         div_cnt <= next_div_cnt;
         neg <= next_neg;
         capture_pos <= next_capture_pos;
         capture_done <= next_capture_done;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Capture error against the exact quotient, scaled by the period length
   logic signed [PROD_W+2:0] acc_err;
   assign acc_err = (PROD_W+3)'($signed(capture_pos - v1s) * $signed({1'b0, N_CYC}))
      - (PROD_W+3)'($signed(v1s - v2s) * $signed({1'b0, stamp}));
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_route_source: assert property (probe_evt && src_motor |=> cap_st == cap_div)
      else $error("motor source event did not start interpolation");
   a_quad_latch: assert property (probe_evt && !src_motor
      |=> capture_pos == $past(quad_count) && capture_done)
      else $error("quadrature count not latched at once");
   a_sample_tick: assert property (tick && ser_st == ser_idle |=> !enc_cs_n)
      else $error("encoder read not started on period tick");
   a_event_stamp: assert property (probe_evt && src_motor |=> stamp == $past(elapsed))
      else $error("timestamp differs from elapsed time");
   a_interp_time: assert property (probe_evt && src_motor ##1 (!probe_evt)[*8]
      |-> ##41 capture_done)
      else $error("interpolated capture late");
   a_vel_snap: assert property (probe_evt && src_motor
      |=> v1s == $past(v1) && v2s == $past(v2))
      else $error("velocity samples not the two preceding");
   a_interp_accuracy: assert property (finish && !probe_evt
      |=> acc_err <= $signed({1'b0, N_CYC}) && acc_err >= -$signed({1'b0, N_CYC}))
      else $error("interpolated capture off by more than one count");
   a_done_hold: assert property (capture_done && !cap_read |=> capture_done)
      else $error("capture done dropped without read");
   a_done_clear: assert property (capture_done && cap_read && !probe_evt && !finish
      |=> !capture_done)
      else $error("capture done not cleared by read");
   c_quad_capture: cover property (probe_evt && !src_motor);
   c_motor_capture: cover property (finish ##1 capture_done);
   c_read_clears: cover property (capture_done && cap_read ##1 !capture_done);
   c_overwrite: cover property (cap_st == cap_div && probe_evt);
endmodule : probe_position_capture

// File: test/axis_feedback_model.sv
`timescale 1ns/1ns
// Far side of the block: quadrature encoder and serial motor encoder
module axis_feedback_model (
   input wire logic mclk,
   input wire logic step_up,
   input wire logic step_dn,
   input wire logic [31:0] position,
   input wire logic enc_sclk,
   input wire logic enc_cs_n,
   output logic quad_a,
   output logic quad_b,
   output logic enc_sdi
);
   logic [1:0] phase = 2'h0;
   logic [31:0] shreg = 32'h0;
   logic cs_q = 1'b1;
   logic sclk_q = 1'b0;
   initial enc_sdi = 1'b0;
   // Gray phase: up walks ab through 00, 01, 11, 10
   assign quad_a = phase[1];
   assign quad_b = phase[1] ^ phase[0];
   // Word latched at frame start, next bit shown after each sclk fall
   always @(posedge mclk) begin
      cs_q <= enc_cs_n;
      sclk_q <= enc_sclk;
      if (step_up) phase <= phase + 2'h1;
      else if (step_dn) phase <= phase - 2'h1;
      if (cs_q && !enc_cs_n) shreg <= position;
      else if (sclk_q && !enc_sclk) shreg <= {shreg[30:0], 1'b0};
      // Deselected line toggles so a stale bit is never read as data
      enc_sdi <= enc_cs_n ? ~enc_sdi : shreg[31];
   end
endmodule : axis_feedback_model

// File: test/test_probe_position_capture.sv
`timescale 1ns/1ns
module test_probe_position_capture;
   localparam int SAMP = 800;
   localparam int SLOW = 20;
   localparam int FAST = probe_capture_pkg::FILT_FAST_CYC;
   localparam int LIMIT = 40000;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic probe_in = 1'b0, filt_slow = 1'b0, src_motor = 1'b0, cap_read = 1'b0;
   logic step_up = 1'b0, step_dn = 1'b0, cs_q = 1'b1;
   logic quad_a, quad_b, enc_sdi, enc_sclk, enc_cs_n, capture_done;
   logic [31:0] capture_pos, position = 32'h0, rng = 32'h45;
   int num_errors = 0, comparisons = 0, cyc = 0, quad_count = 0;
   int t_cs = 0, served = 0, pr = 0, lat = 0, prev = 0;
   int hist[$] = '{0, 0};
   real vel = 0.0, pos_r = 1.0e6;

   probe_position_capture #(.SAMPLE_CYC(SAMP), .FILT_SLOW_CYC(SLOW)) dut (.mclk, .sys_rst,
      .probe_in, .filt_slow, .src_motor, .quad_a, .quad_b, .enc_sdi, .cap_read, .enc_sclk,
      .enc_cs_n, .capture_pos, .capture_done);
   axis_feedback_model model (.mclk, .step_up, .step_dn, .position, .enc_sclk, .enc_cs_n,
      .quad_a, .quad_b, .enc_sdi);

   // Free-running clock
   initial forever #5 mclk = ~mclk;

   // Motor motion, timeout, and bench record of the last two samples
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      cs_q <= enc_cs_n;
      pos_r = pos_r + vel / SAMP;
      position <= 32'($rtoi(pos_r + 0.5));
      if (cs_q && !enc_cs_n) begin
         t_cs <= cyc;
         served <= int'(position);
      end
      // Newest sample first; only the two latest give the velocity
      if (!cs_q && enc_cs_n) begin
         hist.push_front(served);
         hist.delete(2);
      end
      if (cyc > LIMIT) begin
         num_errors++;
         complete_run();
      end
   end

   function automatic int rnd(input int lim);
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return int'(rng % lim);
   endfunction : rnd

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic raise();
      @(posedge mclk);
      probe_in <= 1'b1;
      pr = cyc;
   endtask : raise

   // Bounded wait; a missing capture shows up in the latency check or, for the motor source, the done check
   task automatic wait_done(input int lim);
      lat = 0;
      while (capture_done !== 1'b1 && lat < lim) begin
         @(posedge mclk);
         lat++;
      end
   endtask : wait_done

   task automatic drop(input int n);
      @(posedge mclk);
      probe_in <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask : drop

   task automatic read_cap();
      @(posedge mclk);
      cap_read <= 1'b1;
      @(posedge mclk);
      cap_read <= 1'b0;
      @(posedge mclk);
      check("done_cleared", {31'h0, capture_done}, 32'h0);
   endtask : read_cap

   // Pulse shorter than the filter limit must not capture
   task automatic glitch(input int w);
      raise();
      repeat (w) @(posedge mclk);
      probe_in <= 1'b0;
      repeat (40) @(posedge mclk);
      check("glitch_ignored", {31'h0, capture_done}, 32'h0);
   endtask : glitch

   task automatic quad_move(input int n);
      repeat (n < 0 ? -n : n) begin
         @(posedge mclk);
         step_up <= n > 0;
         step_dn <= n < 0;
         @(posedge mclk);
         step_up <= 1'b0;
         step_dn <= 1'b0;
         repeat (3) @(posedge mclk);
      end
      quad_count += n;
      repeat (4) @(posedge mclk);
   endtask : quad_move

   task automatic complete_run();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // Main sequence
   initial begin
      int n, e, d, stamp;
      repeat (15) @(posedge mclk);
      check("reset_cs", {31'h0, enc_cs_n}, 32'h1);
      check("reset_done", {31'h0, capture_done}, 32'h0);
      check("reset_pos", capture_pos, 32'h0);
      @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge mclk);
      // Quadrature captures, each value overwriting the last
      for (int i = 0; i < 3; i++) begin
         n = i == 1 ? -1 - rnd(40) : 1 + rnd(40);
         quad_move(n);
         if (i > 0) check("hold_pos", capture_pos, 32'(prev));
         raise();
         wait_done(40);
         check("quad_lat", {31'h0, lat >= FAST && lat <= FAST + 8}, 32'h1);
         check("quad_pos", capture_pos, 32'(quad_count));
         drop(14);
         read_cap();
         prev = quad_count;
      end
      $display("quadrature test done");
      glitch(8);
      filt_slow <= 1'b1;
      repeat (4) @(posedge mclk);
      glitch(15);
      raise();
      wait_done(60);
      check("slow_lat", {31'h0, lat >= SLOW && lat <= SLOW + 8}, 32'h1);
      drop(25);
      read_cap();
      filt_slow <= 1'b0;
      $display("filter test done");
      // Motor source at several constant speeds, both directions
      src_motor <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         vel = real'(rnd(300) + 1) * (i % 2 == 1 ? -1.0 : 1.0);
         repeat (3) begin
            wait (!enc_cs_n);
            wait (enc_cs_n);
         end
         repeat (2 + rnd(100)) @(posedge mclk);
         raise();
         stamp = pr - t_cs + FAST + 3; // Two sync stages, filter, event register
         e = hist[0] + int'(real'(hist[0] - hist[1]) * stamp / SAMP);
         wait_done(120);
         d = int'(capture_pos) - e;
         check("motor_done", {31'h0, capture_done}, 32'h1);
         check("motor_interp", {31'h0, d >= -1 && d <= 1}, 32'h1);
         drop(14);
         read_cap();
      end
      $display("motor test done");
      complete_run();
   end
endmodule : test_probe_position_capture
